// ==== hw/annp_defs.svh ====
// Register numbers, field positions and reset values of the register slice.
`ifndef ANNP_DEFS_SVH
`define ANNP_DEFS_SVH
`define ANNP_REG_EXPANSION 5'h06
`define ANNP_REG_NP_ADVERT 5'h07
`define ANNP_REG_MISC 5'h10
`define ANNP_EXP_PD_FAULT 4
`define ANNP_EXP_LP_NP_ABLE 3
`define ANNP_EXP_NP_ABLE 2
`define ANNP_EXP_PAGE_RX 1
`define ANNP_EXP_LP_AN_ABLE 0
`define ANNP_NP_MORE 15
`define ANNP_NP_RSVD 14
`define ANNP_NP_MSG 13
`define ANNP_NP_ACK 12
`define ANNP_NP_TOG 11
`define ANNP_NP_CODE_HI 10
`define ANNP_MISC_FACTORY 15
`define ANNP_MISC_IRQ_POL 14
`define ANNP_MISC_JAM 13
`define ANNP_MISC_RSVD_HI 12
`define ANNP_MISC_RSVD_LO 4
`define ANNP_NP_RESET 16'h2001
`define ANNP_MISC_RESET 16'h0000
`define ANNP_MISC_WMASK 16'hfff0
`define ANNP_ZERO16 16'h0000
`endif

// ==== hw/annp_pkg.sv ====
// Types shared by the register slice.
package annp_pkg;
  typedef logic [15:0] annp_word_type;
  typedef logic [4:0] annp_addr_type;
endpackage : annp_pkg

// ==== hw/annp_regs.sv ====
// Expansion, next-page advertisement and miscellaneous registers of a port.
// How it works
// - Parallel-detect fault latches; read of register clears.
// - Bit 3 shows partner next-page ability.
// - Bit 2 always reads one.
// - New page sets bit 1 until read.
// - Bit 0 shows partner auto-negotiation ability.
// - Bit 15 requests another next page.
// - Message flag resets one, code resets 001.
// - Bit 12 is writable comply acknowledge.
// - Bit 11 holds writable toggle value.
// - Reserved advertisement and expansion bits read zero.
// - Misc bit 14 sets interrupt output polarity.
// - Misc bit 13 forces jam transmission.
`timescale 1ns/100ps
`default_nettype none
`include "annp_defs.svh"
module annp_regs (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire annp_pkg::annp_addr_type reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire annp_pkg::annp_word_type reg_wdata_i,
  output annp_pkg::annp_word_type reg_rdata_o,
  input wire logic pd_fault_evt_i,
  input wire logic page_rx_evt_i,
  input wire logic lp_np_able_i,
  input wire logic lp_an_able_i,
  input wire logic irq_req_i,
  output logic irq_o,
  output logic force_jam_tx_o,
  output annp_pkg::annp_word_type next_page_o
);
  import annp_pkg::*;

  annp_word_type np_advert;
  annp_word_type misc;
  logic pd_fault;
  logic page_rx;
  logic lp_np_sync1, lp_np;
  logic lp_an_sync1, lp_an;
  annp_word_type rdata;
  annp_word_type next_np_advert;
  annp_word_type next_misc;
  logic next_pd_fault;
  logic next_page_rx;
  annp_word_type next_rdata;
  logic rd_exp;

  // Partner ability levels come from the negotiation logic's pins.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      lp_np_sync1 <= 1'b0;
      lp_np <= 1'b0;
      lp_an_sync1 <= 1'b0;
      lp_an <= 1'b0;
    end else begin
      lp_np_sync1 <= lp_np_able_i;
      lp_np <= lp_np_sync1;
      lp_an_sync1 <= lp_an_able_i;
      lp_an <= lp_an_sync1;
    end
  end

  // Next values of the stored bits; a new event wins over a read clear.
  always_comb begin
    rd_exp = reg_rd_i && (reg_addr_i == `ANNP_REG_EXPANSION);
    next_pd_fault = pd_fault_evt_i | (pd_fault & ~rd_exp);
    next_page_rx = page_rx_evt_i | (page_rx & ~rd_exp);
    next_np_advert = np_advert;
    next_misc = misc;
    if (reg_wr_i && reg_addr_i == `ANNP_REG_NP_ADVERT) begin
      next_np_advert = reg_wdata_i;
      next_np_advert[`ANNP_NP_RSVD] = 1'b0;
    end
    if (reg_wr_i && reg_addr_i == `ANNP_REG_MISC) begin
      next_misc = reg_wdata_i & `ANNP_MISC_WMASK;
    end
    next_rdata = `ANNP_ZERO16;
    unique case (reg_addr_i)
      `ANNP_REG_EXPANSION: begin
        next_rdata[`ANNP_EXP_PD_FAULT] = pd_fault;
        next_rdata[`ANNP_EXP_LP_NP_ABLE] = lp_np;
        next_rdata[`ANNP_EXP_NP_ABLE] = 1'b1;
        next_rdata[`ANNP_EXP_PAGE_RX] = page_rx;
        next_rdata[`ANNP_EXP_LP_AN_ABLE] = lp_an;
      end
      `ANNP_REG_NP_ADVERT: begin
        next_rdata = np_advert;
      end
      `ANNP_REG_MISC: begin
        next_rdata = misc;
      end
      default: begin
        next_rdata = `ANNP_ZERO16;
      end
    endcase
  end

  // Register the state and the read word.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      np_advert <= `ANNP_NP_RESET;
      misc <= `ANNP_MISC_RESET;
      pd_fault <= 1'b0;
      page_rx <= 1'b0;
      rdata <= `ANNP_ZERO16;
    end else begin
      np_advert <= next_np_advert;
      misc <= next_misc;
      pd_fault <= next_pd_fault;
      page_rx <= next_page_rx;
      rdata <= next_rdata;
    end
  end

  // Outputs follow the stored control bits.
  assign reg_rdata_o = rdata;
  assign next_page_o = np_advert;
  assign force_jam_tx_o = misc[`ANNP_MISC_JAM];
  assign irq_o = misc[`ANNP_MISC_IRQ_POL] ? irq_req_i : ~irq_req_i;

  // A partner level held for two samples, the depth of the synchroniser.
  sequence s_an_level_held;
    lp_an_able_i ##1 lp_an_able_i;
  endsequence
  sequence s_np_level_held;
    lp_np_able_i ##1 lp_np_able_i;
  endsequence

  // An expansion read with no new event in the same cycle.
  sequence s_exp_read_quiet_pd;
    rd_exp && !pd_fault_evt_i;
  endsequence
  sequence s_exp_read_quiet_pg;
    rd_exp && !page_rx_evt_i;
  endsequence

  // A write strobe aimed at the advertisement register.
  sequence s_np_write;
    reg_wr_i && reg_addr_i == `ANNP_REG_NP_ADVERT;
  endsequence

  // Latched flags: set by events, kept until a read, cleared by a read.
  a_pd_fault_hold: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    pd_fault && !rd_exp |=> pd_fault)
    else $error("fault flag lost");
  a_pd_fault_set: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    pd_fault_evt_i |=> pd_fault)
    else $error("fault flag not set");
  a_pd_fault_clear: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_exp_read_quiet_pd |=> !pd_fault)
    else $error("fault flag not cleared by read");
  a_page_rx_set: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    page_rx_evt_i |=> page_rx)
    else $error("page flag not set");
  a_page_rx_clear: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_exp_read_quiet_pg |=> !page_rx)
    else $error("page flag not cleared by read");

  // The expansion read word shows the flags as they stood before the read.
  a_exp_flags_read: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    reg_addr_i == `ANNP_REG_EXPANSION |=>
    reg_rdata_o[`ANNP_EXP_PD_FAULT] == $past(pd_fault) &&
    reg_rdata_o[`ANNP_EXP_PAGE_RX] == $past(page_rx))
    else $error("expansion flags read wrong");
  a_exp_np_one: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    reg_addr_i == `ANNP_REG_EXPANSION |=>
    reg_rdata_o[`ANNP_EXP_NP_ABLE] && reg_rdata_o[15:5] == 11'h000)
    else $error("expansion read wrong");

  // Advertisement register: writable fields land, the reserved bit stays 0.
  a_np_rsvd_zero: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !np_advert[`ANNP_NP_RSVD])
    else $error("reserved bit set");
  a_np_write: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_np_write |=> next_page_o[`ANNP_NP_MORE] == $past(reg_wdata_i[15]))
    else $error("np write");
  a_np_fields: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_np_write |=> next_page_o[13:0] == $past(reg_wdata_i[13:0]))
    else $error("advertisement fields not written");
  a_np_hold: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !(reg_wr_i && reg_addr_i == `ANNP_REG_NP_ADVERT) |=> $stable(np_advert))
    else $error("advertisement changed without a write");

  // Miscellaneous register: control bits drive their outputs.
  a_jam_follow: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == `ANNP_REG_MISC |=>
    force_jam_tx_o == $past(reg_wdata_i[13]))
    else $error("jam bit");
  a_irq_pol: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    irq_o == (misc[`ANNP_MISC_IRQ_POL] ? irq_req_i : !irq_req_i))
    else $error("polarity");
  a_misc_read: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    reg_addr_i == `ANNP_REG_MISC |=> reg_rdata_o == $past(misc))
    else $error("misc read wrong");
  a_misc_low_zero: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    misc[3:0] == 4'h0)
    else $error("misc low bits set");

  // Reserved register numbers read as zero.
  a_unmapped_zero: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    reg_addr_i != `ANNP_REG_EXPANSION && reg_addr_i != `ANNP_REG_NP_ADVERT &&
    reg_addr_i != `ANNP_REG_MISC |=> reg_rdata_o == `ANNP_ZERO16)
    else $error("unmapped read not zero");

  // Partner ability levels appear after the two synchroniser stages.
  a_lp_sync: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_an_level_held |=> lp_an)
    else $error("an able");
  a_lp_np_sync: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_np_level_held |=> lp_np)
    else $error("np able");
endmodule : annp_regs
`default_nettype wire

// ==== verif/annp_host.sv ====
// Management host model that reads and writes port registers.
`timescale 1ns/100ps
`default_nettype none
module annp_host (
  input wire logic clock_i,
  output annp_pkg::annp_addr_type reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output annp_pkg::annp_word_type reg_wdata_o,
  input wire annp_pkg::annp_word_type reg_rdata_i
);
  import annp_pkg::*;
  // Bus idles with no strobe.
  initial begin
    reg_addr_o = 5'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end
  // One write; misc factory and reserved bits go as zero.
  task automatic wr(input annp_addr_type a, input annp_word_type d);
    @(negedge clock_i);
    reg_addr_o <= a;
    reg_wdata_o <= (a == 5'h10) ? (d & 16'h6000) : d;
    reg_wr_o <= (a < 5'h08) || (a == 5'h10);
    @(negedge clock_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~reg_wdata_o; // Stale data is not left on the bus.
  endtask : wr
  // One read; data is taken one cycle after the address.
  task automatic rd(input annp_addr_type a, output annp_word_type d);
    @(negedge clock_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(negedge clock_i);
    d = reg_rdata_i;
    reg_rd_o <= 1'b0;
  endtask : rd
endmodule : annp_host
`default_nettype wire

// ==== verif/autoneg_nextpage_misc_regs_tb.sv ====
// Self-checking bench of the port register slice.
`timescale 1ns/100ps
`default_nettype none
module autoneg_nextpage_misc_regs_tb;
  import annp_pkg::*;
  logic clock_i = 1'b0, rst_n_i = 1'b0, pd = 1'b0, pg = 1'b0;
  logic lpn = 1'b0, lpa = 1'b0, irq_req = 1'b0, wr, rd, irq, jam;
  annp_addr_type addr;
  annp_word_type wdata, rdata, np, d, m;
  int n_fail = 0, checks_done = 0, cycles = 0, e;
  int unsigned seed = 36826;
  initial forever #10 clock_i = ~clock_i;
  annp_host annp_host_i (.clock_i(clock_i), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
  annp_regs annp_regs_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .pd_fault_evt_i(pd), .page_rx_evt_i(pg),
    .lp_np_able_i(lpn), .lp_an_able_i(lpa), .irq_req_i(irq_req),
    .irq_o(irq), .force_jam_tx_o(jam), .next_page_o(np));
  // Xorshift source of stimulus values.
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Compares a seen word with the expected one.
  task automatic chk(input string n, input annp_word_type s, x);
    checks_done++;
    if (s !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // Prints the counts and the verdict.
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  // Cuts a hang short.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      finish_test();
    end
  end
  // Main sequence with expectations from the register rules.
  initial begin
    repeat (3) @(negedge clock_i);
    rst_n_i = 1'b1;
    annp_host_i.rd(5'h07, d);
    chk("np reset", d, 16'h2001);
    annp_host_i.rd(5'h08, d);
    chk("unmapped", d, 16'h0000);
    annp_host_i.wr(5'h06, 16'hffff);
    annp_host_i.rd(5'h06, d);
    chk("exp", d, 16'h0004);
    repeat (4) begin
      e = xs();
      annp_host_i.wr(5'h07, e[15:0]);
      annp_host_i.rd(5'h07, d);
      chk("np rw", d, e[15:0] & 16'hbfff);
      chk("np out", np, e[15:0] & 16'hbfff);
    end
    for (int i = 0; i < 4; i++) begin
      annp_host_i.rd(5'h10, d);
      chk("misc", d, 16'(i << 13));
      annp_host_i.wr(5'h10, 16'((i + 1) << 13));
      m = 16'((i + 1) << 13) & 16'h6000;
      e = xs();
      irq_req = e[0];
      #1 chk("irq", 16'(irq), 16'(m[14] ? e[0] : !e[0]));
      chk("jam", 16'(jam), 16'(m[13]));
    end
    @(negedge clock_i);
    {lpn, lpa, pd, pg} = 4'hf;
    @(negedge clock_i);
    {pd, pg} = 2'h0;
    repeat (3) @(negedge clock_i);
    annp_host_i.rd(5'h06, d);
    chk("exp set", d, 16'h001f);
    annp_host_i.rd(5'h06, d);
    chk("exp clr", d, 16'h000d);
    finish_test();
  end
endmodule : autoneg_nextpage_misc_regs_tb
`default_nettype wire
